// ### verilog/fcl_loader.sv
// Functional notes
// - Logic held in volatile memory; user mode only after full load.
// - Configuration memory written from serial bitstream, any source but the mask memory.
// - Active mode masters flash, clocked from internal oscillator.
// - Device drives instruction and address to the flash itself.
// - First command is release-from-power-down to wake flash.
// - Wait at least 30 us then fast read from address zero.
// - Configuration also accepted through JTAG, one bit wide.
// - Active 1/2/4 bits, passive 1/2/4/8, JTAG one bit.
// - Optional source: on-chip mask-programmed memory.
module fcl_loader
  import fcl_pkg::*;
(
  input wire logic clk,
  input wire logic resetn,
  input wire logic config_reset_n,
  input wire logic [1:0] cfg_source,
  input wire logic [1:0] cfg_width,
  output logic flash_sck,
  output logic flash_cs_n,
  output logic [3:0] flash_dq_out,
  output logic [3:0] flash_dq_oe_n,
  input wire logic [3:0] flash_dq_in,
  input wire logic link_clk,
  input wire logic link_resetn,
  input wire logic [7:0] link_data,
  output logic mem_we,
  output logic [ADDR_W-1:0] mem_addr,
  output logic [WORD_W-1:0] mem_wdata,
  output logic config_done,
  output logic user_mode
);
  import fcl_pkg::*;

  typedef enum logic [6:0] {
    ST_IDLE = 7'h01,
    ST_WAKE = 7'h02,
    ST_WAIT = 7'h04,
    ST_CMD = 7'h08,
    ST_DATA = 7'h10,
    ST_SLAVE = 7'h20,
    ST_DONE = 7'h40
  } fcl_state_e;

  // Mask-programmed image, arbitrary pattern
  function automatic logic [7:0] fcl_mask_byte(input logic [5:0] a);
    fcl_mask_byte = {2'h0, a} ^ 8'h5a;
  endfunction

  fcl_state_e state;
  logic [2:0] rst_sync;
  logic [1:0] src_sync0, src_sync1;
  logic [1:0] wid_sync0, wid_sync1;
  logic [3:0] dq_sync0, dq_sync1;
  logic [2:0] tgl_sync;
  logic [9:0] wait_cnt;
  logic [5:0] bit_cnt;
  logic [39:0] tx_shift;
  logic phase;
  logic rx_arm;
  logic [7:0] rx_shift;
  logic [3:0] rx_fill;
  logic [ADDR_W:0] words;
  logic link_en;
  logic [7:0] link_byte;
  logic link_tgl;
  logic [7:0] link_byte_q;

  wire start = rst_sync[2] == 1'b0 && rst_sync[1] == 1'b1;
  // Two-flop input delay: read the bit launched one sck period earlier
  wire sck_rise = phase == 1'b0 && rx_arm;
  wire act_x2 = src_sync1 == SRC_ACTIVE && wid_sync1 == WID_X2;
  wire act_x4 = src_sync1 == SRC_ACTIVE && wid_sync1 == WID_X4;
  wire [3:0] rx_step = act_x4 ? 4'h4 : act_x2 ? 4'h2 : 4'h1;
  wire [7:0] next_rx = act_x4 ? {rx_shift[3:0], dq_sync1}
    : act_x2 ? {rx_shift[5:0], dq_sync1[1:0]}
    : {rx_shift[6:0], dq_sync1[1]};
  wire [3:0] next_fill = rx_fill + rx_step;
  wire image_full = words == 7'(MEM_DEPTH);
  wire link_strobe = tgl_sync[2] ^ tgl_sync[1];
  wire [5:0] cmd_bits = 6'(40);

  always_ff @(posedge clk) begin
    rst_sync <= {rst_sync[1:0], config_reset_n};
    src_sync0 <= cfg_source;
    src_sync1 <= src_sync0;
    wid_sync0 <= cfg_width;
    wid_sync1 <= wid_sync0;
    dq_sync0 <= flash_dq_in;
    dq_sync1 <= dq_sync0;
    tgl_sync <= {tgl_sync[1:0], link_tgl};
    link_byte_q <= link_byte;
  end

  always_ff @(posedge clk) begin
    if (!resetn || rst_sync[1] == 1'b0) begin
      state <= ST_IDLE;
      flash_sck <= 1'b0;
      flash_cs_n <= 1'b1;
      flash_dq_out <= 4'h0;
      flash_dq_oe_n <= 4'hf;
      wait_cnt <= 10'h000;
      bit_cnt <= 6'h00;
      tx_shift <= 40'h0000000000;
      phase <= 1'b0;
      rx_arm <= 1'b0;
      rx_shift <= 8'h00;
      rx_fill <= 4'h0;
      words <= 7'h00;
      link_en <= 1'b0;
      mem_we <= 1'b0;
      mem_addr <= 6'h00;
      mem_wdata <= 8'h00;
      config_done <= 1'b0;
      user_mode <= 1'b0;
    end else begin
      mem_we <= 1'b0;
      if (mem_we) begin
        mem_addr <= mem_addr + 6'h01;
      end
      case (state)
        ST_IDLE: begin
          if (start && src_sync1 == SRC_ACTIVE) begin
            state <= ST_WAKE;
            flash_dq_out <= {3'h0, CMD_WAKE[7]};
            tx_shift <= {CMD_WAKE[6:0], 33'h000000000};
            bit_cnt <= 6'h08;
            flash_cs_n <= 1'b0;
            flash_dq_oe_n <= 4'he;
          end else if (start && src_sync1 == SRC_MASK) begin
            state <= ST_SLAVE;
          end else if (start) begin
            state <= ST_SLAVE;
            link_en <= 1'b1;
          end
        end
        ST_WAKE, ST_CMD: begin
          // Internal clock divider: sck is clk/2
          phase <= ~phase;
          flash_sck <= ~phase;
          // Bits change on the falling edge, stable at the rise
          if (!phase) begin
            bit_cnt <= bit_cnt - 6'h01;
          end else if (bit_cnt == 6'h00) begin
            flash_sck <= 1'b0;
            phase <= 1'b0;
            if (state == ST_WAKE) begin
              state <= ST_WAIT;
              flash_cs_n <= 1'b1;
              wait_cnt <= 10'(WAKE_WAIT_CYC);
            end else begin
              state <= ST_DATA;
              flash_dq_oe_n <= 4'hf;
            end
          end else begin
            flash_dq_out <= {3'h0, tx_shift[39]};
            tx_shift <= {tx_shift[38:0], 1'b0};
          end
        end
        ST_WAIT: begin
          if (wait_cnt == 10'h000) begin
            state <= ST_CMD;
            flash_dq_out <= {3'h0, CMD_FAST_READ[7]};
            tx_shift <= {CMD_FAST_READ[6:0], FLASH_START, 9'h000};
            bit_cnt <= cmd_bits;
            flash_cs_n <= 1'b0;
            flash_dq_oe_n <= 4'he;
          end else begin
            wait_cnt <= wait_cnt - 10'h001;
          end
        end
        ST_DATA: begin
          phase <= ~phase;
          flash_sck <= ~phase;
          rx_arm <= 1'b1;
          if (sck_rise) begin
            rx_shift <= next_rx;
            if (next_fill >= 4'h8) begin
              rx_fill <= 4'h0;
              mem_we <= 1'b1;
              mem_wdata <= next_rx;
              words <= words + 7'h01;
            end else begin
              rx_fill <= next_fill;
            end
          end
          if (image_full) begin
            state <= ST_DONE;
            flash_cs_n <= 1'b1;
            flash_sck <= 1'b0;
            phase <= 1'b0;
          end
        end
        ST_SLAVE: begin
          if (src_sync1 == SRC_MASK && !mem_we) begin
            mem_we <= 1'b1;
            mem_wdata <= fcl_mask_byte(words[5:0]);
            words <= words + 7'h01;
          end else if (link_strobe) begin
            mem_we <= 1'b1;
            mem_wdata <= link_byte_q;
            words <= words + 7'h01;
          end
          if (image_full) begin
            state <= ST_DONE;
            link_en <= 1'b0;
          end
        end
        ST_DONE: begin
          if (!mem_we) begin
            config_done <= 1'b1;
            user_mode <= 1'b1;
          end
        end
        default: state <= ST_IDLE;
      endcase
    end
  end

  fcl_link_rx u_link (
    .link_clk(link_clk),
    .link_resetn(link_resetn),
    .link_en(link_en),
    .link_jtag(src_sync1 == SRC_JTAG),
    .link_width(src_sync1 == SRC_JTAG ? WID_X1 : wid_sync1),
    .link_data(link_data),
    .byte_out(link_byte),
    .byte_tgl(link_tgl)
  );
endmodule

// ### verilog/fcl_pkg.sv
package fcl_pkg;
  // Configuration sources
  localparam logic [1:0] SRC_ACTIVE = 2'h0;
  localparam logic [1:0] SRC_PASSIVE = 2'h1;
  localparam logic [1:0] SRC_JTAG = 2'h2;
  localparam logic [1:0] SRC_MASK = 2'h3;
  // Bus width codes: 1, 2, 4, 8 data lines
  localparam logic [1:0] WID_X1 = 2'h0;
  localparam logic [1:0] WID_X2 = 2'h1;
  localparam logic [1:0] WID_X4 = 2'h2;
  localparam logic [1:0] WID_X8 = 2'h3;
  // Flash commands and start address
  localparam logic [7:0] CMD_WAKE = 8'hab;
  localparam logic [7:0] CMD_FAST_READ = 8'h0b;
  localparam logic [23:0] FLASH_START = 24'h000000;
  localparam int DUMMY_BITS = 8;
  // Timing at the 20 MHz system clock
  localparam int CLK_HZ = 20000000;
  localparam int WAKE_WAIT_US = 30;
  localparam int WAKE_WAIT_CYC = (WAKE_WAIT_US * CLK_HZ + 999999) / 1000000;
  localparam int SCK_HALF = 1;
  // Configuration memory geometry
  localparam int WORD_W = 8;
  localparam int MEM_DEPTH = 64;
  localparam int ADDR_W = 6;
  localparam int BIT_CNT_W = 9;
  localparam logic [BIT_CNT_W-1:0] IMAGE_BITS = 9'h1ff;
endpackage

// ### verilog/fcl_link_rx.sv
// Passive and JTAG receive on the link clock; bytes cross by toggle
module fcl_link_rx
  import fcl_pkg::*;
(
  input wire logic link_clk,
  input wire logic link_resetn,
  input wire logic link_en,
  input wire logic link_jtag,
  input wire logic [1:0] link_width,
  input wire logic [7:0] link_data,
  output logic [7:0] byte_out,
  output logic byte_tgl
);
  logic [7:0] shreg;
  logic [3:0] fill;
  logic [3:0] step;
  logic [7:0] next_shreg;
  logic [3:0] next_fill;

  assign step = link_jtag ? 4'h1 : (4'h1 << link_width);
  assign next_shreg = (link_jtag || link_width == WID_X1)
    ? {shreg[6:0], link_data[0]}
    : (link_width == WID_X2) ? {shreg[5:0], link_data[1:0]}
    : (link_width == WID_X4) ? {shreg[3:0], link_data[3:0]}
    : link_data;
  assign next_fill = fill + step;

  always_ff @(posedge link_clk) begin
    if (!link_resetn || !link_en) begin
      shreg <= 8'h00;
      fill <= 4'h0;
      byte_out <= 8'h00;
      byte_tgl <= 1'b0;
    end else begin
      shreg <= next_shreg;
      if (next_fill >= 4'h8) begin
        fill <= 4'h0;
        byte_out <= next_shreg;
        byte_tgl <= ~byte_tgl;
      end else begin
        fill <= next_fill;
      end
    end
  end
endmodule

// ### verif/fcl_flash_model.sv
module fcl_flash_model (
  input wire logic sck,
  input wire logic cs_n,
  input wire logic mosi,
  input wire logic [1:0] width,
  input wire logic [511:0] image,
  output logic [3:0] dq,
  output logic [7:0] wake,
  output logic [39:0] hdr
);
  timeunit 1ns;
  timeprecision 100ps;
  int n = 0;
  int k = 0;
  logic [515:0] pad;
  assign pad = {image, 4'h0};
  initial dq = 4'h0;
  always @(negedge cs_n) begin
    n <= 0;
    k <= 0;
  end
  always @(posedge sck) if (!cs_n && n < 40) begin
    hdr <= {hdr[38:0], mosi};
    n <= n + 1;
  end
  // Data only once the read header is in
  always @(negedge sck) if (!cs_n && n >= 40 && k < 512) begin
    dq <= width == 2'h2 ? pad[515-k -: 4] : pad[515-k -: 4] >> 2;
    k <= k + (width == 2'h2 ? 4 : width == 2'h1 ? 2 : 1);
  end
  always @(posedge cs_n) begin
    if (n == 8) wake <= hdr[7:0];
    // Released lines do not hold their last level
    dq <= ~dq;
  end
endmodule

// ### verif/fcl_loader_properties.sv
module fcl_loader_checker (
  input wire logic clk,
  input wire logic resetn,
  input wire logic config_reset_n,
  input wire logic flash_sck,
  input wire logic flash_cs_n,
  input wire logic [3:0] flash_dq_out,
  input wire logic [3:0] flash_dq_oe_n,
  input wire logic mem_we,
  input wire logic [fcl_pkg::ADDR_W-1:0] mem_addr,
  input wire logic config_done,
  input wire logic user_mode
);
  import fcl_pkg::*;
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);
  logic woke;
  logic [9:0] gap;
  logic [5:0] rise;
  always_ff @(posedge clk) begin
    if (!resetn || !config_reset_n) woke <= 1'b0;
    else if ($rose(flash_cs_n)) woke <= 1'b1;
  end
  always_ff @(posedge clk) begin
    if (!resetn || !flash_cs_n) gap <= 10'h0;
    else if (gap != 10'h3ff) gap <= gap + 10'h1;
  end
  always_ff @(posedge clk) begin
    if (flash_cs_n) rise <= 6'h0;
    else if ($rose(flash_sck) && rise != 6'h3f) rise <= rise + 6'h1;
  end
  sequence cmd_edge;
    $rose(flash_sck) && rise == 6'h0;
  endsequence
  sequence addr_edge;
    $rose(flash_sck) && woke && rise inside {[8:31]};
  endsequence
  chk_user_gate: assert property (user_mode |-> config_done)
    else $error("user mode early");
  chk_done_hold: assert property
    ((config_done && config_reset_n) [*3] |=> config_done) else $error("done lost");
  chk_we_pulse: assert property (mem_we |=> !mem_we)
    else $error("write pulse long");
  chk_addr_step: assert property (mem_we && mem_addr != 6'h3f |=>
    mem_addr == $past(mem_addr) + 6'h1) else $error("address step");
  chk_cmd_first: assert property (cmd_edge |->
    flash_dq_out[0] == !woke && !flash_dq_oe_n[0]) else $error("command bit");
  chk_addr_zero: assert property (addr_edge |-> !flash_dq_out[0])
    else $error("address not zero");
  chk_wake_gap: assert property ($fell(flash_cs_n) && woke |->
    gap >= 10'h258) else $error("wake wait short");
  chk_cs_release: assert property ($rose(flash_cs_n) && woke |->
    ##[0:4] config_done) else $error("select released early");
endmodule
bind fcl_loader fcl_loader_checker chk_i (.clk, .resetn, .config_reset_n,
  .flash_sck, .flash_cs_n, .flash_dq_out, .flash_dq_oe_n, .mem_we, .mem_addr,
  .config_done, .user_mode);

// ### verif/fcl_loader_bench.sv
`define CHK(a, b) begin \
  samples_checked++; \
  if ((a) !== (b)) begin \
    fail_count++; \
    $display("CHECK FAILED t=%0t got=%h exp=%h", $time, a, b); \
  end \
end
module fcl_loader_bench;
  timeunit 1ns;
  timeprecision 100ps;
  import fcl_pkg::*;
  logic clk, resetn, config_reset_n, link_clk, link_resetn, lrun;
  logic [1:0] cfg_source, cfg_width;
  logic flash_sck, flash_cs_n, mem_we, config_done, user_mode;
  logic [3:0] flash_dq_out, flash_dq_oe_n, mdq, flash_dq_in;
  logic [7:0] link_data, wake, mem_wdata;
  logic [5:0] mem_addr;
  logic [39:0] hdr;
  logic [519:0] img;
  logic [3:0] cases [9] = '{4'h0, 4'h1, 4'h2, 4'h4, 4'h5, 4'h6, 4'h7, 4'h8, 4'hc};
  int seed = 67, fail_count = 0, samples_checked = 0, nb, p, i;
  assign flash_dq_in = (flash_dq_out & ~flash_dq_oe_n) | (mdq & flash_dq_oe_n);
  always #25 clk = ~clk;
  // Link clock stands still between frames
  always #62.5 link_clk = lrun & ~link_clk;
  fcl_loader dut (.clk, .resetn, .config_reset_n, .cfg_source, .cfg_width,
    .flash_sck, .flash_cs_n, .flash_dq_out, .flash_dq_oe_n, .flash_dq_in,
    .link_clk, .link_resetn, .link_data, .mem_we, .mem_addr, .mem_wdata,
    .config_done, .user_mode);
  fcl_flash_model flash (.sck(flash_sck), .cs_n(flash_cs_n),
    .mosi(flash_dq_out[0]), .width(cfg_width), .image(img[519:8]), .dq(mdq),
    .wake, .hdr);
  function automatic int lw();
    return cfg_source == SRC_JTAG ? 1 : 1 << cfg_width;
  endfunction
  always @(posedge link_clk) if (lrun && p < 512) begin
    p = p + lw();
    link_data <= img[519-p -: 8] >> (8 - lw());
  end
  always @(posedge clk) if (mem_we === 1'b1) begin
    `CHK(mem_addr, nb[5:0])
    if (cfg_source != SRC_MASK) `CHK(mem_wdata, img[519-8*nb -: 8])
    nb++;
  end
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic run(input logic [3:0] c);
    config_reset_n <= 1'b0;
    for (i = 0; i < 16; i++) img[8+32*i +: 32] = $random(seed);
    nb = 0;
    p = 0;
    repeat (8) @(posedge clk);
    {cfg_source, cfg_width} <= c;
    @(posedge clk);
    config_reset_n <= 1'b1;
    link_data <= img[519 -: 8] >> (8 - lw());
    repeat (10) @(posedge clk);
    lrun = cfg_source inside {SRC_PASSIVE, SRC_JTAG};
    for (i = 0; i < 4000 && config_done !== 1'b1; i++) @(posedge clk);
    // Let the link side see its enable drop before the clock stops
    repeat (8) @(posedge clk);
    lrun = 1'b0;
    if (config_done !== 1'b1) begin
      fail_count++;
      wrap_up();
    end
    `CHK(user_mode, 1'b1)
    `CHK(nb, 64)
    `CHK(flash_cs_n, 1'b1)
    if (cfg_source == SRC_ACTIVE) begin
      `CHK(wake, CMD_WAKE)
      `CHK(hdr[39:8], {CMD_FAST_READ, FLASH_START})
    end
  endtask
  initial begin
    {clk, resetn, config_reset_n, link_clk, link_resetn} = 5'h0;
    {cfg_source, cfg_width, link_data, img} = '0;
    lrun = 1'b1;
    repeat (16) @(posedge clk);
    resetn <= 1'b1;
    link_resetn <= 1'b1;
    lrun = 1'b0;
    foreach (cases[j]) run(cases[j]);
    wrap_up();
  end
endmodule
